// [logic/ivpm_top.sv]
// Purpose: Interrupt vector and priority map with Wishbone registers
// Assumes: Single 100 MHz clock, synchronous active-high reset
// Notes: Sources latch into sticky status; winner shown as a vector
// What this block does
// - Two-byte vector per line, descending from top
// - Two-bit level per line, six banks
// - Equal levels: lowest line number served first
// - External channels n and n+4 share line n for n 0 to 3; 8 and 9 share line 21
// - Listed shared sources OR onto one line
// - Pulse unit halves use separate lines
`timescale 1ns/100ps
`default_nettype none
`include "ivpm_defs.svh"
module ivpm_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [9:0] extIntReq,
   input wire logic serialReq,
   input wire logic deadTimeTripReq,
   input wire logic compTimer0LoReq,
   input wire logic compTimer0HiReq,
   input wire logic linRxReq,
   input wire logic linTxReq,
   input wire logic pulseUnit0LoReq,
   input wire logic pulseUnit0HiReq,
   input wire logic pulseUnit1LoReq,
   input wire logic pulseUnit1HiReq,
   input wire logic pulseUnit2LoReq,
   input wire logic pulseUnit2HiReq,
   input wire logic compTimer1LoReq,
   input wire logic compTimer1HiReq,
   input wire logic reloadTimerReq,
   input wire logic motorSeqWriteReq,
   input wire logic twoWireReq,
   input wire logic pulseTimer16Req,
   input wire logic motorSeqPosReq,
   input wire logic adcReq,
   input wire logic timeBaseReq,
   input wire logic watchPrescalerReq,
   input wire logic comparatorReq,
   input wire logic flashReq,
   output logic irq,
   output logic vecValid,
   output logic [4:0] vecLine,
   output logic [1:0] vecLevel,
   output logic [15:0] vecUpperAddr,
   output logic [15:0] vecLowerAddr
);
   ////////////////////////////////////////////////////////////////////
   // Declarations
   logic [23:0] lines;
   logic [7:0] level_ff [`IVPM_NUM_BANKS];
   logic [47:0] levelsFlat;
   logic [23:0] status_ff;
   logic [23:0] nxt_status;
   logic [23:0] mask_ff;
   logic [23:0] nxt_mask;
   logic [23:0] pending;
   logic [23:0] clrBits;
   logic [31:0] byteMask;
   logic [31:0] actWord;
   logic [31:0] nxt_rdData;
   logic [31:0] rdData_ff;
   logic ack_ff;
   logic irq_ff;
   logic vecValid_ff;
   logic [4:0] vecLine_ff;
   logic [1:0] vecLevel_ff;
   logic [15:0] vecUpper_ff;
   logic [15:0] nxt_vecUpper;
   logic pickValid;
   ivpm_pkg::ivpm_line_t pickLine;
   ivpm_pkg::ivpm_level_t pickLevel;
   logic reqLive;
   logic ackGo;
   logic wrDo;
   logic statusHit;
   logic maskHit;
   logic activeHit;
   logic [`IVPM_NUM_BANKS-1:0] bankHit;
   logic bankAny;

   ////////////////////////////////////////////////////////////////////
   // Source folding onto request lines
   ivpm_source_map uMap (
      .clk(clk),
      .sys_rst(sys_rst),
      .extIntReq(extIntReq),
      .serialReq(serialReq),
      .deadTimeTripReq(deadTimeTripReq),
      .compTimer0LoReq(compTimer0LoReq),
      .compTimer0HiReq(compTimer0HiReq),
      .linRxReq(linRxReq),
      .linTxReq(linTxReq),
      .pulseUnit0LoReq(pulseUnit0LoReq),
      .pulseUnit0HiReq(pulseUnit0HiReq),
      .pulseUnit1LoReq(pulseUnit1LoReq),
      .pulseUnit1HiReq(pulseUnit1HiReq),
      .pulseUnit2LoReq(pulseUnit2LoReq),
      .pulseUnit2HiReq(pulseUnit2HiReq),
      .compTimer1LoReq(compTimer1LoReq),
      .compTimer1HiReq(compTimer1HiReq),
      .reloadTimerReq(reloadTimerReq),
      .motorSeqWriteReq(motorSeqWriteReq),
      .twoWireReq(twoWireReq),
      .pulseTimer16Req(pulseTimer16Req),
      .motorSeqPosReq(motorSeqPosReq),
      .adcReq(adcReq),
      .timeBaseReq(timeBaseReq),
      .watchPrescalerReq(watchPrescalerReq),
      .comparatorReq(comparatorReq),
      .flashReq(flashReq),
      .lines(lines)
   );

   ////////////////////////////////////////////////////////////////////
   // Bus handshake: ack one cycle after the request, write at ack
   assign reqLive = wb_cyc_i & wb_stb_i;
   assign ackGo = reqLive & ~ack_ff;
   assign wrDo = reqLive & wb_we_i & ack_ff;
   assign byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Address decode
   assign statusHit = wb_adr_i == `IVPM_OFS_STATUS;
   assign maskHit = wb_adr_i == `IVPM_OFS_MASK;
   assign activeHit = wb_adr_i == `IVPM_OFS_ACTIVE;
   assign bankAny = |bankHit;

   ////////////////////////////////////////////////////////////////////
   // Level banks, four lines of two bits each
   genvar g;
   generate
      for (g = 0; g < `IVPM_NUM_BANKS; g++) begin : gBank
         assign bankHit[g] =
            wb_adr_i == `IVPM_OFS_LVL0 + 8'(g) * `IVPM_OFS_STEP;
         assign levelsFlat[8*g +: 8] = level_ff[g];
         // Byte lane 0 carries the bank
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               level_ff[g] <= `IVPM_LVL_RESET;
            end else if (wrDo && bankHit[g] && wb_sel_i[0]) begin
               level_ff[g] <= wb_dat_i[7:0];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Sticky status, write one to clear; a new event beats the clear
   assign clrBits = (wrDo && statusHit) ? (wb_dat_i[23:0] & byteMask[23:0])
                                        : 24'h000000;
   assign nxt_status = (status_ff & ~clrBits) | lines;
   assign nxt_mask = (wrDo && maskHit)
      ? ((mask_ff & ~byteMask[23:0]) | (wb_dat_i[23:0] & byteMask[23:0]))
      : mask_ff;
   assign pending = status_ff & mask_ff;

   // Status and mask registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_ff <= 24'h000000;
         mask_ff <= `IVPM_MASK_RESET;
      end else begin
         status_ff <= nxt_status;
         mask_ff <= nxt_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Arbitration among unmasked pending lines
   ivpm_arbiter uArb (
      .clk(clk),
      .sys_rst(sys_rst),
      .req(pending),
      .levels(levelsFlat),
      .pickValid(pickValid),
      .pickLine(pickLine),
      .pickLevel(pickLevel)
   );

   // Vector address of the winner, upper byte at the even address
   assign nxt_vecUpper = `IVPM_VEC_BASE - {10'h000, pickLine, 1'b0};

   // Winner and interrupt registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_ff <= 1'b0;
         vecValid_ff <= 1'b0;
         vecLine_ff <= 5'h00;
         vecLevel_ff <= 2'h3;
         vecUpper_ff <= `IVPM_VEC_BASE;
      end else begin
         irq_ff <= |pending;
         vecValid_ff <= pickValid;
         vecLine_ff <= pickLine;
         vecLevel_ff <= pickLevel;
         vecUpper_ff <= nxt_vecUpper;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read data, zero for unmapped offsets
   assign actWord = {vecValid_ff, 5'h00, vecLevel_ff, 3'h0, vecLine_ff,
                     vecUpper_ff};

   // Read selection
   always_comb begin
      nxt_rdData = 32'h00000000;
      if (bankAny) begin
         for (int i = 0; i < `IVPM_NUM_BANKS; i++) begin
            if (bankHit[i]) begin
               nxt_rdData = {24'h000000, level_ff[i]};
            end
         end
      end else if (statusHit) begin
         nxt_rdData = {8'h00, status_ff};
      end else if (maskHit) begin
         nxt_rdData = {8'h00, mask_ff};
      end else if (activeHit) begin
         nxt_rdData = actWord;
      end
   end

   // Bus answer registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_ff <= 1'b0;
         rdData_ff <= 32'h00000000;
      end else begin
         ack_ff <= ackGo;
         if (ackGo) begin
            rdData_ff <= nxt_rdData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdData_ff;
   assign irq = irq_ff;
   assign vecValid = vecValid_ff;
   assign vecLine = vecLine_ff;
   assign vecLevel = vecLevel_ff;
   assign vecUpperAddr = vecUpper_ff;
   assign vecLowerAddr = {vecUpper_ff[15:1], 1'b1};

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_vector_addr_map: assert property (
      vecValid_ff |-> vecUpperAddr == `IVPM_VEC_BASE - 16'(2 * vecLine_ff)
      && vecUpperAddr >= `IVPM_VEC_FLOOR && vecUpperAddr[0] == 1'b0
      && vecLowerAddr == vecUpperAddr + 16'h0001)
      else $error("vector address does not match line");
   a_bank_write_use: assert property (
      (wrDo && bankHit[5] && wb_sel_i[0]) |=>
      levelsFlat[47:40] == $past(wb_dat_i[7:0]))
      else $error("top level bank not written");
   a_winner_level: assert property (
      (vecValid_ff && $stable(levelsFlat)) |-> vecLevel_ff ==
      levelsFlat[2*vecLine_ff +: 2])
      else $error("reported level not the line field");
   a_event_beats_clear: assert property (
      (lines[0] && wrDo && statusHit && wb_dat_i[0] && wb_sel_i[0])
      |=> status_ff[0])
      else $error("event lost to a clear");
   a_irq_follows: assert property (
      (|pending) |=> irq ##1 (irq == $past(|pending)))
      else $error("interrupt output not following status");
   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");

   // Bus answer checks
   a_ack_next_cycle: assert property (
      (reqLive && !ack_ff) |=> wb_ack_o)
      else $error("request not answered in the next cycle");
   a_ack_needs_req: assert property (
      wb_ack_o |-> $past(reqLive))
      else $error("ack without a request");
   a_read_data_hold: assert property (
      !ackGo |=> $stable(wb_dat_o))
      else $error("read data changed without a request");
   a_unmapped_read_zero: assert property (
      (ackGo && !bankAny && !statusHit && !maskHit && !activeHit)
      |=> wb_dat_o == 32'h00000000)
      else $error("unmapped offset read not zero");
   a_status_read_back: assert property (
      (ackGo && statusHit) |=> wb_dat_o == {8'h00, $past(status_ff)})
      else $error("status read does not match register");
   a_active_read_back: assert property (
      (ackGo && activeHit) |=> wb_dat_o[15:0] == $past(vecUpperAddr)
      && wb_dat_o[31] == $past(vecValid))
      else $error("active word does not match vector");

   // Status and mask checks
   a_event_sets_status: assert property (
      (lines != 24'h000000) |=> (status_ff & $past(lines)) == $past(lines))
      else $error("event did not set its status bit");
   a_status_sticky: assert property (
      !(wrDo && statusHit) |=>
      (status_ff & $past(status_ff)) == $past(status_ff))
      else $error("status bit dropped without a clear");
   a_clear_by_one: assert property (
      (wrDo && statusHit && wb_sel_i == 4'hf && lines == 24'h000000)
      |=> (status_ff & $past(wb_dat_i[23:0])) == 24'h000000)
      else $error("written one did not clear status");
   a_mask_write: assert property (
      (wrDo && maskHit && wb_sel_i == 4'hf)
      |=> mask_ff == $past(wb_dat_i[23:0]))
      else $error("mask write not taken");
   a_mask_lane_guard: assert property (
      (wrDo && maskHit && wb_sel_i == 4'h0) |=> $stable(mask_ff))
      else $error("mask changed with no byte lane");
   a_bank_lane_guard: assert property (
      (wrDo && bankAny && !wb_sel_i[0]) |=> $stable(levelsFlat))
      else $error("level bank written without its byte lane");

   // Vector output checks
   a_valid_follows: assert property (
      1'b1 |=> vecValid == ($past(pending) != 24'h000000))
      else $error("vector valid not following pending lines");
   a_irq_valid_agree: assert property (
      irq == vecValid)
      else $error("interrupt and vector valid disagree");
   a_idle_vector: assert property (
      !vecValid_ff |-> vecLine_ff == 5'h00 && vecLevel_ff == 2'h3
      && vecUpper_ff == `IVPM_VEC_BASE)
      else $error("idle vector not at line zero");
   a_vector_in_range: assert property (
      vecLine_ff < 5'h18 && vecUpperAddr >= `IVPM_VEC_FLOOR)
      else $error("vector outside the line table");
endmodule
`default_nettype wire

// [logic/ivpm_defs.svh]
// Purpose: Constants of the interrupt vector and priority map
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes: Included by ivpm_top and ivpm_arbiter
`ifndef IVPM_DEFS_SVH
`define IVPM_DEFS_SVH
`define IVPM_NUM_LINES 24
`define IVPM_NUM_BANKS 6
`define IVPM_VEC_BASE 16'hfffa
`define IVPM_VEC_FLOOR 16'hffcc
`define IVPM_OFS_LVL0 8'h00
`define IVPM_OFS_STEP 8'h04
`define IVPM_OFS_STATUS 8'h18
`define IVPM_OFS_MASK 8'h1c
`define IVPM_OFS_ACTIVE 8'h20
`define IVPM_LVL_RESET 8'hff
`define IVPM_MASK_RESET 24'h000000
`define IVPM_ACT_VALID_BIT 31
`define IVPM_ACT_LEVEL_LSB 24
`define IVPM_ACT_LINE_LSB 16
`endif

// [logic/ivpm_pkg.sv]
// Purpose: Types of the interrupt vector and priority map
// Assumes: Nothing
// Notes: Constants live in ivpm_defs.svh
package ivpm_pkg;
   typedef logic [1:0] ivpm_level_t;
   typedef logic [4:0] ivpm_line_t;
endpackage

// [logic/ivpm_source_map.sv]
// Purpose: Fold peripheral sources onto 24 request lines
// Assumes: Sources are synchronous one-cycle pulses or levels
// Notes: Pure OR network, checked on clk
`timescale 1ns/100ps
`default_nettype none
module ivpm_source_map (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [9:0] extIntReq,
   input wire logic serialReq,
   input wire logic deadTimeTripReq,
   input wire logic compTimer0LoReq,
   input wire logic compTimer0HiReq,
   input wire logic linRxReq,
   input wire logic linTxReq,
   input wire logic pulseUnit0LoReq,
   input wire logic pulseUnit0HiReq,
   input wire logic pulseUnit1LoReq,
   input wire logic pulseUnit1HiReq,
   input wire logic pulseUnit2LoReq,
   input wire logic pulseUnit2HiReq,
   input wire logic compTimer1LoReq,
   input wire logic compTimer1HiReq,
   input wire logic reloadTimerReq,
   input wire logic motorSeqWriteReq,
   input wire logic twoWireReq,
   input wire logic pulseTimer16Req,
   input wire logic motorSeqPosReq,
   input wire logic adcReq,
   input wire logic timeBaseReq,
   input wire logic watchPrescalerReq,
   input wire logic comparatorReq,
   input wire logic flashReq,
   output logic [23:0] lines
);
   ////////////////////////////////////////////////////////////////////
   // Line assembly, line 0 in bit 0
   assign lines[3:0] = extIntReq[3:0] | extIntReq[7:4];
   assign lines[4] = serialReq | deadTimeTripReq;
   assign lines[5] = compTimer0LoReq;
   assign lines[6] = compTimer0HiReq;
   assign lines[7] = linRxReq;
   assign lines[8] = linTxReq;
   assign lines[9] = pulseUnit1LoReq;
   assign lines[10] = pulseUnit1HiReq;
   assign lines[11] = pulseUnit2HiReq;
   assign lines[12] = pulseUnit0HiReq;
   assign lines[13] = pulseUnit0LoReq;
   assign lines[14] = compTimer1HiReq;
   assign lines[15] = pulseUnit2LoReq;
   assign lines[16] = reloadTimerReq | motorSeqWriteReq | twoWireReq;
   assign lines[17] = pulseTimer16Req | motorSeqPosReq;
   assign lines[18] = adcReq;
   assign lines[19] = timeBaseReq | watchPrescalerReq;
   assign lines[20] = comparatorReq;
   assign lines[21] = extIntReq[8] | extIntReq[9];
   assign lines[22] = compTimer1LoReq;
   assign lines[23] = flashReq;

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_ext_line_share: assert property (
      extIntReq[5] |-> lines[1] && (lines[2] == (extIntReq[2] | extIntReq[6])))
      else $error("external channel pair not merged");
   a_shared_or_lines: assert property (
      (deadTimeTripReq |-> lines[4]) and (twoWireReq |-> lines[16])
      and (watchPrescalerReq |-> lines[19]))
      else $error("shared source missing on its line");
   a_pulse_half_split: assert property (
      (pulseUnit1HiReq && !pulseUnit1LoReq) |-> (lines[10] && !lines[9]))
      else $error("pulse unit halves not separated");
endmodule
`default_nettype wire

// [logic/ivpm_arbiter.sv]
// Purpose: Pick the most urgent pending line
// Assumes: Level 0 is most urgent, level 3 least
// Notes: Combinational; ties go to the lowest line number
`timescale 1ns/100ps
`default_nettype none
`include "ivpm_defs.svh"
module ivpm_arbiter (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [23:0] req,
   input wire logic [47:0] levels,
   output logic pickValid,
   output ivpm_pkg::ivpm_line_t pickLine,
   output ivpm_pkg::ivpm_level_t pickLevel
);
   ivpm_pkg::ivpm_level_t lvl [`IVPM_NUM_LINES];
   logic [23:0] sameLvl;
   logic [23:0] moreUrgent;
   logic [23:0] lowerLines;

   ////////////////////////////////////////////////////////////////////
   // Per-line level field and comparisons
   genvar g;
   generate
      for (g = 0; g < `IVPM_NUM_LINES; g++) begin : gLine
         assign lvl[g] = levels[2*g +: 2];
         assign sameLvl[g] = lvl[g] == pickLevel;
         assign moreUrgent[g] = lvl[g] < pickLevel;
      end
   endgenerate
   assign lowerLines = (24'h000001 << pickLine) - 24'h000001;

   // Scan from line 23 down so the lowest line wins a tie
   always_comb begin
      pickValid = 1'b0;
      pickLine = 5'h00;
      pickLevel = 2'h3;
      for (int i = `IVPM_NUM_LINES - 1; i >= 0; i--) begin
         if (req[i] && (!pickValid || lvl[i] <= pickLevel)) begin
            pickValid = 1'b1;
            pickLine = 5'(i);
            pickLevel = lvl[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_level_field_pick: assert property (
      pickValid |-> req[pickLine] && pickLevel == lvl[pickLine])
      else $error("picked level differs from line field");
   a_tie_low_line: assert property (
      pickValid |-> (req & sameLvl & lowerLines) == 24'h000000)
      else $error("lower line at same level skipped");
   a_urgent_first: assert property (
      (|req) |-> pickValid && (req & moreUrgent) == 24'h000000)
      else $error("more urgent request skipped");
endmodule
`default_nettype wire

// [verification/ivpm_cpu_model.sv]
// Purpose: Core side that fetches the handler vector on request
// Assumes: irq is a level, vector outputs settle with it
// Notes: Latches the fetched address pair on each new request
`timescale 1ns/100ps
`default_nettype none
module ivpm_cpu_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic irq,
   input wire logic vecValid,
   input wire logic [15:0] vecUpperAddr,
   input wire logic [15:0] vecLowerAddr,
   output logic [15:0] fetchUpper,
   output logic [15:0] fetchLower,
   output logic [7:0] fetchCount
);
   logic irqSeen;
   // Latch upper and lower byte address in the same cycle on a new request
   always @(posedge clk) begin
      if (sys_rst) begin
         irqSeen <= 1'b0;
         fetchUpper <= 16'h0000;
         fetchLower <= 16'h0000;
         fetchCount <= 8'h00;
      end else begin
         irqSeen <= irq;
         if (irq && !irqSeen && vecValid) begin
            fetchUpper <= vecUpperAddr;
            fetchLower <= vecLowerAddr;
            fetchCount <= fetchCount + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// [verification/ivpm_top_test.sv]
// Purpose: Self-checking bench of the vector and priority map
// Assumes: Classic Wishbone, master waits for ack however long
// Notes: Sources are driven as one vector, mapped to ports
`timescale 1ns/100ps
`default_nettype none
module ivpm_top_test;
   logic clk, sysRst, cyc, stb, we, ack, irq, vecValid;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] datI, datO, q;
   logic [33:0] src;
   logic [4:0] vecLine;
   logic [1:0] vecLevel;
   logic [15:0] vUp, vLo, fUp, fLo;
   logic [7:0] fCnt;
   int num_errors, num_checks, cycles;
   // Line of each source bit, in src order
   byte lineOf [34] = '{0, 1, 2, 3, 0, 1, 2, 3, 21, 21, 4, 4, 5, 6, 7,
      8, 13, 12, 9, 10, 15, 11, 22, 14, 16, 16, 16, 17, 17, 18, 19, 19,
      20, 23};
   ////////////////////////////////////////////////////////////////////
   ivpm_top u_ivpm_top (.clk(clk), .sys_rst(sysRst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
      .extIntReq(src[9:0]), .serialReq(src[10]),
      .deadTimeTripReq(src[11]), .compTimer0LoReq(src[12]),
      .compTimer0HiReq(src[13]), .linRxReq(src[14]),
      .linTxReq(src[15]), .pulseUnit0LoReq(src[16]),
      .pulseUnit0HiReq(src[17]), .pulseUnit1LoReq(src[18]),
      .pulseUnit1HiReq(src[19]), .pulseUnit2LoReq(src[20]),
      .pulseUnit2HiReq(src[21]), .compTimer1LoReq(src[22]),
      .compTimer1HiReq(src[23]), .reloadTimerReq(src[24]),
      .motorSeqWriteReq(src[25]), .twoWireReq(src[26]),
      .pulseTimer16Req(src[27]), .motorSeqPosReq(src[28]),
      .adcReq(src[29]), .timeBaseReq(src[30]),
      .watchPrescalerReq(src[31]), .comparatorReq(src[32]),
      .flashReq(src[33]), .irq(irq), .vecValid(vecValid),
      .vecLine(vecLine), .vecLevel(vecLevel), .vecUpperAddr(vUp),
      .vecLowerAddr(vLo));
   ivpm_cpu_model u_ivpm_cpu_model (.clk(clk), .sys_rst(sysRst),
      .irq(irq), .vecValid(vecValid), .vecUpperAddr(vUp),
      .vecLowerAddr(vLo), .fetchUpper(fUp), .fetchLower(fLo),
      .fetchCount(fCnt));
   ////////////////////////////////////////////////////////////////////
   // Clock and cycle ceiling
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      datI <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic pulse(input logic [33:0] m);
      @(posedge clk);
      src <= m;
      @(posedge clk);
      src <= '0;
      repeat (3) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      for (int k = 0; k < 6; k++) rd(8'(4 * k), 32'h000000ff);
      rd(8'h18, 32'h0);
      rd(8'h1c, 32'h0);
      rd(8'h40, 32'h0);
      rd(8'h20, 32'h0300fffa);
   endtask
   // Every source on its line, vector pair of that line
   task automatic t_source_map();
      logic [15:0] up;
      wb(1'b1, 8'h1c, 32'h00ffffff);
      for (int i = 0; i < 34; i++) begin
         up = 16'hfffa - 16'(2 * lineOf[i]);
         pulse(34'h1 << i);
         chk(irq, 1'b1);
         chk(vecLine, lineOf[i]);
         chk(vUp, up);
         chk(vLo, up + 16'h1);
         rd(8'h18, 32'h1 << lineOf[i]);
         wb(1'b1, 8'h18, 32'h1 << lineOf[i]);
         repeat (3) @(posedge clk);
         chk(irq, 1'b0);
      end
   endtask
   // Level first, then line rank
   task automatic t_priority();
      pulse((34'h1 << 12) | (34'h1 << 33));
      chk(vecLine, 5'd5);
      chk(vecLevel, 2'd3);
      chk(fUp, 16'hfff0);
      wb(1'b1, 8'h14, 32'h3f);
      repeat (3) @(posedge clk);
      chk(vecLine, 5'd23);
      chk(vecLevel, 2'd0);
      chk(vUp, 16'hffcc);
      rd(8'h20, 32'h8017ffcc);
      wb(1'b1, 8'h04, 32'hf3);
      repeat (3) @(posedge clk);
      chk(vecLine, 5'd5);
      wb(1'b1, 8'h18, 32'h00800020);
      wb(1'b1, 8'h04, 32'hff);
      wb(1'b1, 8'h14, 32'hff);
   endtask
   // Masked event sets status only
   task automatic t_mask();
      wb(1'b1, 8'h1c, 32'h0);
      pulse(34'h1 << 4);
      chk(irq, 1'b0);
      chk(vecValid, 1'b0);
      rd(8'h18, 32'h1);
      wb(1'b1, 8'h1c, 32'h1);
      repeat (3) @(posedge clk);
      chk(irq, 1'b1);
      chk(fLo, 16'hfffb);
      wb(1'b1, 8'h18, 32'h1);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      chk(fCnt, 8'h24);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      num_errors = 0;
      num_checks = 0;
      cycles = 0;
      sysRst = 1'b1;
      {cyc, stb, we} = 3'b000;
      adr = 8'h00;
      sel = 4'h0;
      datI = 32'h0;
      src = '0;
      repeat (8) @(posedge clk);
      sysRst <= 1'b0;
      t_reset_values();
      t_source_map();
      t_priority();
      t_mask();
      report_and_stop();
   end
endmodule
`default_nettype wire
